// *** inc/mt_seq_pkg.sv ***
package mt_seq_pkg;

  // Status codes
  localparam logic [7:0] ST_START     = 8'h08;
  localparam logic [7:0] ST_RSTART    = 8'h10;
  localparam logic [7:0] ST_ADDR_ACK  = 8'h18;
  localparam logic [7:0] ST_ADDR_NACK = 8'h20;
  localparam logic [7:0] ST_DATA_ACK  = 8'h28;
  localparam logic [7:0] ST_DATA_NACK = 8'h30;
  localparam logic [7:0] ST_LOST      = 8'h38;
  localparam logic [7:0] ST_SLV_W     = 8'h68;
  localparam logic [7:0] ST_SLV_GC    = 8'h78;
  localparam logic [7:0] ST_SLV_R     = 8'hB0;
  localparam logic [7:0] ST_ADR2_ACK  = 8'hD0;
  localparam logic [7:0] ST_ADR2_NACK = 8'hD8;
  localparam logic [7:0] ST_IDLE      = 8'hF8;

  // Byte layout
  localparam int         DATA_W     = 8;
  localparam int         FIFO_DEPTH = 16;
  localparam int         MSB        = 7;
  localparam int         RW_BIT     = 0;
  localparam int         TEN_LO     = 3;
  localparam logic [4:0] TEN_HDR    = 5'h1E;
  localparam logic [7:0] GC_ADDR    = 8'h00;
  localparam logic [3:0] ACK_BIT    = 4'h8;

  // Bit phases and condition steps
  localparam logic [1:0] PH_DRIVE = 2'h0;
  localparam logic [1:0] PH_RISE  = 2'h1;
  localparam logic [1:0] PH_HIGH  = 2'h2;
  localparam logic [1:0] PH_FALL  = 2'h3;
  localparam logic [1:0] STEP_0   = 2'h0;
  localparam logic [1:0] STEP_1   = 2'h1;
  localparam logic [1:0] STEP_2   = 2'h2;
  localparam logic [1:0] STEP_3   = 2'h3;

  // Timing: quarter bit of a 100 kHz clock, bus free time
  localparam int CLK_PERIOD_NS = 4;
  localparam int QUARTER_NS    = 2500;
  localparam int BUS_FREE_NS   = 4700;
  localparam int QUARTER_CYC   = (QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUS_FREE_CYC  = (BUS_FREE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W         = 12;
  localparam logic [CNT_W-1:0] Q_LAST    = CNT_W'(QUARTER_CYC - 1);
  localparam logic [CNT_W-1:0] FREE_LOAD = CNT_W'(BUS_FREE_CYC);

  typedef struct packed {
    logic begin_set;
    logic halt_set;
    logic flag_clear;
    logic ack_enable;
  } sw_ctrl_t;

  typedef struct packed {
    logic [7:0] code;
    logic       service_flag;
    logic       begin_condition_request;
    logic       halt_condition_request;
    logic       busy;
  } sw_stat_t;

endpackage

// *** rtl/data_fifo.sv ***
`timescale 1ns/100ps
module data_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  input  wire logic         in_valid_in,
  input  wire logic [W-1:0] in_data_in,
  output logic              in_ready_out,
  output logic              out_valid_out,
  output logic [W-1:0]      out_data_out,
  input  wire logic         out_ready_in
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wp_ff;
  logic [AW-1:0] rp_ff;
  logic [AW:0]   cnt_ff;
  logic [AW:0]   nxt_cnt;
  logic          push;
  logic          pop;

  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_ready_in && out_valid_out;
  assign out_valid_out = (cnt_ff != '0);
  assign out_data_out  = mem[rp_ff];
  assign nxt_cnt       = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wp_ff] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wp_ff        <= '0;
      rp_ff        <= '0;
      cnt_ff       <= '0;
      in_ready_out <= 1'b0;
    end else begin
      wp_ff        <= wp_ff + AW'(push);
      rp_ff        <= rp_ff + AW'(pop);
      cnt_ff       <= nxt_cnt;
      in_ready_out <= (nxt_cnt != (AW+1)'(DEPTH));
    end
  end
endmodule // data_fifo

// *** rtl/mt_sequencer.sv ***
`timescale 1ns/100ps
module mt_sequencer (
  input  wire logic                  clk_in,
  input  wire logic                  rst_n_in,
  input  wire mt_seq_pkg::sw_ctrl_t  ctrl_in,
  input  wire logic                  wr_valid_in,
  input  wire logic [7:0]            wr_data_in,
  output logic                       wr_ready_out,
  input  wire logic [6:0]            own_slave_address_in,
  input  wire logic                  gc_enable_in,
  output mt_seq_pkg::sw_stat_t       stat_out,
  input  wire logic                  scl_in,
  output logic                       scl_out,
  output logic                       scl_oe_out,
  input  wire logic                  sda_in,
  output logic                       sda_out,
  output logic                       sda_oe_out
);
  import mt_seq_pkg::*;

  typedef enum logic [3:0] {
    S_IDLE, S_WAIT_FREE, S_RSTART, S_WAIT_SW, S_BYTE, S_STOP,
    S_SLV_ADDR, S_SLV_ACK, S_SLV_RX, S_SLV_END, S_SLV_TX
  } seq_state_t;
  typedef enum logic [1:0] {K_ADDR, K_ADDR2, K_DATA} byte_kind_t;

  logic [2:0]       scl_s_ff;
  logic [2:0]       sda_s_ff;
  logic             scl_lvl_ff;
  logic             sda_lvl_ff;
  logic             scl_rise;
  logic             scl_fall;
  logic             sda_rise;
  logic             sda_fall;
  logic             busy_ff;
  logic [CNT_W-1:0] free_cnt_ff;
  logic [CNT_W-1:0] q_cnt_ff;
  logic             tick;
  logic             bus_free;
  seq_state_t       state_ff;
  byte_kind_t       kind_ff;
  logic [1:0]       step_ff;
  logic [1:0]       phase_ff;
  logic [3:0]       bit_ff;
  logic [7:0]       shift_ff;
  logic [7:0]       rx_ff;
  logic [7:0]       code_ff;
  logic             flag_ff;
  logic             begin_req_ff;
  logic             halt_req_ff;
  logic             rs_ff;
  logic             ten_ff;
  logic             ack_lvl_ff;
  logic             drive_lvl_ff;
  logic             f_valid;
  logic [7:0]       f_data;
  logic             want_data;
  logic             pop;
  logic             after_byte;
  logic             lost;

  // Software writes to the data register queue here; an empty queue stalls the bus
  data_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_in        (clk_in),
    .rst_n_in      (rst_n_in),
    .in_valid_in   (wr_valid_in),
    .in_data_in    (wr_data_in),
    .in_ready_out  (wr_ready_out),
    .out_valid_out (f_valid),
    .out_data_out  (f_data),
    .out_ready_in  (pop)
  );

  logic             scl_oe_ff;
  logic             sda_oe_ff;

  assign stat_out   = {code_ff, flag_ff, begin_req_ff, halt_req_ff, busy_ff};
  assign scl_out    = drive_lvl_ff;
  assign sda_out    = drive_lvl_ff;
  assign scl_oe_out = scl_oe_ff;
  assign sda_oe_out = sda_oe_ff;

  // A level counts only once the last two stages agree
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      scl_s_ff     <= 3'h7;
      sda_s_ff     <= 3'h7;
      scl_lvl_ff   <= 1'b1;
      sda_lvl_ff   <= 1'b1;
      drive_lvl_ff <= 1'b0;
    end else begin
      scl_s_ff <= {scl_s_ff[1:0], scl_in};
      sda_s_ff <= {sda_s_ff[1:0], sda_in};
      if (scl_s_ff[1] == scl_s_ff[2]) begin
        scl_lvl_ff <= scl_s_ff[2];
      end
      if (sda_s_ff[1] == sda_s_ff[2]) begin
        sda_lvl_ff <= sda_s_ff[2];
      end
    end
  end

  assign scl_rise = (scl_s_ff[1] == scl_s_ff[2]) && scl_s_ff[2] && !scl_lvl_ff;
  assign scl_fall = (scl_s_ff[1] == scl_s_ff[2]) && !scl_s_ff[2] && scl_lvl_ff;
  assign sda_rise = (sda_s_ff[1] == sda_s_ff[2]) && sda_s_ff[2] && !sda_lvl_ff;
  assign sda_fall = (sda_s_ff[1] == sda_s_ff[2]) && !sda_s_ff[2] && sda_lvl_ff;

  // Bus busy between START and STOP, plus the free time after STOP
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      busy_ff     <= 1'b0;
      free_cnt_ff <= '0;
    end else if (sda_fall && scl_lvl_ff) begin
      busy_ff     <= 1'b1;
      free_cnt_ff <= '0;
    end else if (sda_rise && scl_lvl_ff) begin
      busy_ff     <= 1'b0;
      free_cnt_ff <= FREE_LOAD;
    end else if (free_cnt_ff != '0) begin
      free_cnt_ff <= free_cnt_ff - CNT_W'(1);
    end
  end

  assign bus_free = !busy_ff && (free_cnt_ff == '0);

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q_cnt_ff <= '0;
    end else begin
      q_cnt_ff <= tick ? '0 : q_cnt_ff + CNT_W'(1);
    end
  end

  assign tick = (q_cnt_ff == Q_LAST);

  assign after_byte = code_ff inside {ST_ADDR_ACK, ST_ADDR_NACK, ST_DATA_ACK, ST_DATA_NACK,
                                      ST_ADR2_ACK, ST_ADR2_NACK};
  // Our driven 1 read back as 0 while the clock is high
  assign lost = (state_ff == S_BYTE) && tick && (phase_ff == PH_HIGH) && scl_lvl_ff &&
                (bit_ff != ACK_BIT) && shift_ff[MSB] && !sda_lvl_ff;

  always_comb begin
    want_data = 1'b0;
    if ((state_ff == S_WAIT_SW) && !flag_ff) begin
      if (code_ff inside {ST_START, ST_RSTART, ST_SLV_R}) begin
        want_data = 1'b1;
      end else if (after_byte) begin
        want_data = !halt_req_ff && !begin_req_ff;
      end
    end
  end

  assign pop = want_data && f_valid;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_ff     <= S_IDLE;
      kind_ff      <= K_ADDR;
      step_ff      <= STEP_0;
      phase_ff     <= PH_DRIVE;
      bit_ff       <= '0;
      shift_ff     <= '0;
      rx_ff        <= '0;
      code_ff      <= ST_IDLE;
      flag_ff      <= 1'b0;
      begin_req_ff <= 1'b0;
      halt_req_ff  <= 1'b0;
      rs_ff        <= 1'b0;
      ten_ff       <= 1'b0;
      ack_lvl_ff   <= 1'b1;
      scl_oe_ff    <= 1'b0;
      sda_oe_ff    <= 1'b0;
    end else begin
      // A flag set below in the same cycle wins over this clear
      if (ctrl_in.flag_clear) begin
        flag_ff <= 1'b0;
      end
      unique case (state_ff)
        S_IDLE: begin
          if (begin_req_ff) begin
            state_ff <= S_WAIT_FREE;
          end
        end
        S_WAIT_FREE: begin
          if (bus_free) begin
            state_ff <= S_RSTART;
            step_ff  <= STEP_2;
            rs_ff    <= 1'b0;
          end
        end
        S_RSTART: begin
          if (tick) begin
            if (step_ff == STEP_0) begin
              sda_oe_ff <= 1'b0;
              step_ff   <= STEP_1;
            end else if (step_ff == STEP_1) begin
              scl_oe_ff <= 1'b0;
              step_ff   <= STEP_2;
            end else if (step_ff == STEP_2) begin
              if (scl_lvl_ff) begin
                sda_oe_ff <= 1'b1;
                step_ff   <= STEP_3;
              end
            end else begin
              scl_oe_ff    <= 1'b1;
              code_ff      <= rs_ff ? ST_RSTART : ST_START;
              flag_ff      <= 1'b1;
              begin_req_ff <= 1'b0;
              state_ff     <= S_WAIT_SW;
            end
          end
        end
        S_STOP: begin
          if (tick) begin
            if (step_ff == STEP_0) begin
              sda_oe_ff <= 1'b1;
              step_ff   <= STEP_1;
            end else if (step_ff == STEP_1) begin
              scl_oe_ff <= 1'b0;
              step_ff   <= STEP_2;
            end else if (scl_lvl_ff) begin
              sda_oe_ff   <= 1'b0;
              halt_req_ff <= 1'b0;
              code_ff     <= ST_IDLE;
              state_ff    <= begin_req_ff ? S_WAIT_FREE : S_IDLE;
            end
          end
        end
        S_WAIT_SW: begin
          if (!flag_ff) begin
            if (code_ff == ST_LOST) begin
              state_ff <= begin_req_ff ? S_WAIT_FREE : S_IDLE;
            end else if (code_ff inside {ST_SLV_W, ST_SLV_GC}) begin
              scl_oe_ff <= 1'b0;
              bit_ff    <= '0;
              state_ff  <= S_SLV_RX;
            end else if (after_byte && halt_req_ff) begin
              state_ff <= S_STOP;
              step_ff  <= STEP_0;
            end else if (after_byte && begin_req_ff) begin
              state_ff <= S_RSTART;
              step_ff  <= STEP_0;
              rs_ff    <= 1'b1;
            end else if (pop) begin
              shift_ff <= f_data;
              bit_ff   <= '0;
              if (code_ff == ST_SLV_R) begin
                sda_oe_ff <= !f_data[MSB];
                scl_oe_ff <= 1'b0;
                state_ff  <= S_SLV_TX;
              end else begin
                phase_ff <= PH_DRIVE;
                state_ff <= S_BYTE;
                if (code_ff inside {ST_START, ST_RSTART}) begin
                  kind_ff <= K_ADDR;
                  ten_ff  <= (f_data[MSB:TEN_LO] == TEN_HDR);
                end else if (ten_ff && code_ff inside {ST_ADDR_ACK, ST_ADDR_NACK}) begin
                  kind_ff <= K_ADDR2;
                  ten_ff  <= 1'b0;
                end else begin
                  kind_ff <= K_DATA;
                end
              end
            end
          end
        end
        S_BYTE: begin
          if (tick) begin
            unique case (phase_ff)
              PH_DRIVE: begin
                sda_oe_ff <= (bit_ff == ACK_BIT) ? 1'b0 : !shift_ff[MSB];
                phase_ff  <= PH_RISE;
              end
              PH_RISE: begin
                scl_oe_ff <= 1'b0;
                phase_ff  <= PH_HIGH;
              end
              PH_HIGH: begin
                // A stretched clock simply holds this phase
                if (scl_lvl_ff) begin
                  rx_ff      <= {rx_ff[MSB-1:0], sda_lvl_ff};
                  ack_lvl_ff <= sda_lvl_ff;
                  if (lost) begin
                    sda_oe_ff <= 1'b0;
                    if (kind_ff == K_ADDR) begin
                      bit_ff   <= bit_ff + 4'h1;
                      state_ff <= S_SLV_ADDR;
                    end else begin
                      code_ff  <= ST_LOST;
                      flag_ff  <= 1'b1;
                      state_ff <= S_WAIT_SW;
                    end
                  end else begin
                    phase_ff <= PH_FALL;
                  end
                end
              end
              PH_FALL: begin
                // clock held low on each step
                scl_oe_ff <= 1'b1;
                if (bit_ff == ACK_BIT) begin
                  flag_ff  <= 1'b1;
                  state_ff <= S_WAIT_SW;
                  if (kind_ff == K_ADDR) begin
                    code_ff <= ack_lvl_ff ? ST_ADDR_NACK : ST_ADDR_ACK;
                  end else if (kind_ff == K_ADDR2) begin
                    code_ff <= ack_lvl_ff ? ST_ADR2_NACK : ST_ADR2_ACK;
                  end else begin
                    code_ff <= ack_lvl_ff ? ST_DATA_NACK : ST_DATA_ACK;
                  end
                end else begin
                  shift_ff <= {shift_ff[MSB-1:0], 1'b0};
                  bit_ff   <= bit_ff + 4'h1;
                  phase_ff <= PH_DRIVE;
                end
              end
            endcase
          end
        end
        S_SLV_ADDR: begin
          if (scl_rise) begin
            rx_ff  <= {rx_ff[MSB-1:0], sda_lvl_ff};
            bit_ff <= bit_ff + 4'h1;
          end else if (scl_fall && (bit_ff == ACK_BIT)) begin
            if (gc_enable_in && (rx_ff == GC_ADDR)) begin
              code_ff   <= ST_SLV_GC;
              sda_oe_ff <= 1'b1;
              state_ff  <= S_SLV_ACK;
            end else if (rx_ff[MSB:RW_BIT+1] == own_slave_address_in) begin
              code_ff   <= rx_ff[RW_BIT] ? ST_SLV_R : ST_SLV_W;
              sda_oe_ff <= 1'b1;
              state_ff  <= S_SLV_ACK;
            end else begin
              code_ff  <= ST_LOST;
              flag_ff  <= 1'b1;
              state_ff <= S_WAIT_SW;
            end
          end
        end
        S_SLV_ACK: begin
          if (scl_fall) begin
            sda_oe_ff <= 1'b0;
            scl_oe_ff <= 1'b1;
            flag_ff   <= 1'b1;
            state_ff  <= S_WAIT_SW;
          end
        end
        S_SLV_RX: begin
          if (scl_rise) begin
            rx_ff  <= {rx_ff[MSB-1:0], sda_lvl_ff};
            bit_ff <= bit_ff + 4'h1;
          end else if (scl_fall && (bit_ff == ACK_BIT)) begin
            sda_oe_ff <= ctrl_in.ack_enable;
            state_ff  <= S_SLV_END;
          end
        end
        S_SLV_END: begin
          if (scl_fall) begin
            sda_oe_ff <= 1'b0;
            code_ff   <= ST_IDLE;
            state_ff  <= S_IDLE;
          end
        end
        S_SLV_TX: begin
          if (scl_rise) begin
            if (bit_ff == ACK_BIT) begin
              code_ff  <= ST_IDLE;
              state_ff <= S_IDLE;
            end else begin
              bit_ff <= bit_ff + 4'h1;
            end
          end else if (scl_fall) begin
            if (bit_ff == ACK_BIT) begin
              sda_oe_ff <= 1'b0;
            end else begin
              sda_oe_ff <= !shift_ff[MSB-1];
              shift_ff  <= {shift_ff[MSB-1:0], 1'b0};
            end
          end
        end
        default: state_ff <= S_IDLE;
      endcase
      if (ctrl_in.begin_set) begin
        begin_req_ff <= 1'b1;
      end
      if (ctrl_in.halt_set) begin
        halt_req_ff <= 1'b1;
      end
    end
  end

  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence stop_done_s;
    (state_ff == S_STOP) && (step_ff == STEP_2) && tick && scl_lvl_ff && !ctrl_in.halt_set;
  endsequence

  sequence byte_end_s(byte_kind_t k);
    (state_ff == S_BYTE) && (phase_ff == PH_FALL) && tick && (bit_ff == ACK_BIT) && (kind_ff == k);
  endsequence

  free_start_a: assert property (
    (state_ff == S_WAIT_FREE) && !bus_free |=> state_ff != S_RSTART)
    else $error("start attempted on a busy bus");
  start_code_a: assert property (
    $rose(flag_ff) && ($past(state_ff) == S_RSTART) && !rs_ff |-> code_ff == ST_START)
    else $error("first start not reported as 08h");
  pause_hold_a: assert property (
    (state_ff == S_WAIT_SW) && flag_ff |=> state_ff == S_WAIT_SW)
    else $error("left pause while flag set");
  addr_code_a: assert property (
    byte_end_s(K_ADDR) |=> flag_ff && (code_ff == ($past(ack_lvl_ff) ? ST_ADDR_NACK : ST_ADDR_ACK)))
    else $error("address status wrong");
  ten_code_a: assert property (
    byte_end_s(K_ADDR2) |=> flag_ff && (code_ff == ($past(ack_lvl_ff) ? ST_ADR2_NACK : ST_ADR2_ACK)))
    else $error("second address status wrong");
  lost_idle_a: assert property (
    (state_ff == S_WAIT_SW) && (code_ff == ST_LOST) && !flag_ff && !begin_req_ff
    |=> state_ff == S_IDLE)
    else $error("lost arbitration did not go idle");
  rstart_code_a: assert property (
    $rose(flag_ff) && ($past(state_ff) == S_RSTART) && rs_ff |-> code_ff == ST_RSTART)
    else $error("repeated start not reported as 10h");
  data_code_a: assert property (
    byte_end_s(K_DATA) |=> flag_ff && (code_ff == ($past(ack_lvl_ff) ? ST_DATA_NACK : ST_DATA_ACK)))
    else $error("data status wrong");
  halt_clear_a: assert property (
    stop_done_s |=> !halt_req_ff && (state_ff inside {S_IDLE, S_WAIT_FREE}) ##1 !sda_oe_ff)
    else $error("stop did not clear halt request");
  addr_loss_a: assert property (
    lost && (kind_ff == K_ADDR) |=> (state_ff == S_SLV_ADDR) && !sda_oe_ff && !scl_oe_ff)
    else $error("address loss did not switch to slave");
  scl_hold_a: assert property (
    (state_ff == S_WAIT_SW) && flag_ff && (code_ff != ST_LOST) |-> scl_oe_ff)
    else $error("clock released while flag set");
endmodule // mt_sequencer

// *** testbench/bus_slave_model.sv ***
`timescale 1ns/100ps
module bus_slave_model (
  input  wire logic scl_in,
  input  wire logic sda_in,
  input  wire logic nack_in,
  output logic      sda_oe_out,
  output logic [7:0] rx_byte_out
);
  int         bits = 0;
  logic [7:0] sh = 8'h00;
  initial sda_oe_out = 1'b0;
  // Start or stop on the wire restarts the bit count
  always @(sda_in) begin
    if (scl_in) begin
      bits = 0;
    end
  end
  // Last byte seen before the acknowledge bit
  always @(posedge scl_in) begin
    bits = bits + 1;
    sh = {sh[6:0], sda_in};
    if (bits == 8) begin
      rx_byte_out = sh;
    end
  end
  always @(negedge scl_in) begin
    sda_oe_out = (bits == 8) && !nack_in;
    if (bits == 9) begin
      bits = 0;
    end
  end
endmodule // bus_slave_model

// *** testbench/i2c_master_transmit_sequencer_tb.sv ***
`timescale 1ns/100ps
module i2c_master_transmit_sequencer_tb;
  import mt_seq_pkg::*;
  logic       clk_in = 1'b0;
  logic       rst_n_in = 1'b0;
  sw_ctrl_t   ctrl = 4'h1;
  logic       wr_valid = 1'b0;
  logic [7:0] wr_data = 8'h00;
  logic       nack = 1'b0;
  logic       wr_ready, scl_q, scl_oe, sda_q, sda_oe, slv_oe;
  logic [7:0] rx_byte;
  sw_stat_t   stat;
  int         bad_count = 0;
  int         total_checks = 0;
  int         cycles = 0;
  // Open-drain wires with pull-ups
  wire        scl = !scl_oe;
  wire        sda = !(sda_oe | slv_oe);
  always #2 clk_in = ~clk_in;
  mt_sequencer dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .ctrl_in(ctrl), .wr_valid_in(wr_valid),
    .wr_data_in(wr_data), .wr_ready_out(wr_ready), .own_slave_address_in(7'h2B), .gc_enable_in(1'b0),
    .stat_out(stat), .scl_in(scl), .scl_out(scl_q), .scl_oe_out(scl_oe), .sda_in(sda), .sda_out(sda_q),
    .sda_oe_out(sda_oe));
  bus_slave_model slave (.scl_in(scl), .sda_in(sda), .nack_in(nack), .sda_oe_out(slv_oe),
    .rx_byte_out(rx_byte));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick;
    @(posedge clk_in);
    #1;
  endtask
  task automatic pulse(input logic b, input logic h, input logic c);
    ctrl = {b, h, c, 1'b1};
    tick();
    ctrl = 4'h1;
    tick();
  endtask
  task automatic push(input logic [7:0] d);
    wr_valid = 1'b1;
    wr_data = d;
    while (wr_ready !== 1'b1) tick();
    tick();
    wr_valid = 1'b0;
  endtask
  // Bounded wait for the service flag, then code and clock hold
  task automatic wait_flag(input logic [7:0] exp);
    int n;
    n = 0;
    while (stat.service_flag !== 1'b1 && n < 30000) begin
      tick();
      n++;
    end
    chk({7'h00, stat.service_flag}, 8'h01);
    chk(stat.code, exp);
    chk({7'h00, scl_oe}, 8'h01);
  endtask
  task automatic run_transfer;
    int n;
    n = 0;
    pulse(1'b1, 1'b0, 1'b0);
    chk({7'h00, stat.begin_condition_request}, 8'h01);
    wait_flag(ST_START);
    chk({7'h00, stat.begin_condition_request}, 8'h00);
    chk({6'h00, scl_q, sda_q}, 8'h00);
    push(8'hA4);
    pulse(1'b0, 1'b0, 1'b1);
    wait_flag(ST_ADDR_ACK);
    chk(rx_byte, 8'hA4);
    pulse(1'b1, 1'b0, 1'b1);
    wait_flag(ST_RSTART);
    push(8'hF0);
    nack = 1'b1;
    pulse(1'b0, 1'b0, 1'b1);
    wait_flag(ST_ADDR_NACK);
    chk(rx_byte, 8'hF0);
    push(8'h5A);
    pulse(1'b0, 1'b0, 1'b1);
    wait_flag(ST_ADR2_NACK);
    chk(rx_byte, 8'h5A);
    push(8'h96);
    nack = 1'b0;
    pulse(1'b0, 1'b0, 1'b1);
    wait_flag(ST_DATA_ACK);
    chk(rx_byte, 8'h96);
    pulse(1'b0, 1'b1, 1'b1);
    while (stat.code !== ST_IDLE && n < 5000) begin
      tick();
      n++;
    end
    chk(stat.code, ST_IDLE);
    // Busy follows the STOP only after the input synchroniser
    repeat (6) tick();
    chk({6'h00, stat.halt_condition_request, stat.busy}, 8'h00);
    chk({7'h00, sda}, 8'h01);
    $display("test run_transfer done");
  endtask
  task automatic fill_queue;
    int n;
    n = 0;
    wr_valid = 1'b1;
    wr_data = 8'h3C;
    while (wr_ready === 1'b1 && n < 40) begin
      tick();
      n++;
    end
    wr_valid = 1'b0;
    chk(8'(n), 8'(FIFO_DEPTH));
    $display("test fill_queue done");
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Ceiling sized for four bytes at 100 kHz plus margin
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 99000) begin
      bad_count++;
      summarize();
    end
  end
  initial begin
    repeat (12) @(posedge clk_in);
    #1;
    rst_n_in = 1'b1;
    tick();
    tick();
    chk(stat.code, ST_IDLE);
    run_transfer();
    fill_queue();
    summarize();
  end
endmodule // i2c_master_transmit_sequencer_tb
